// [design/otp_wiper_store_reset_shutdown.sv]
// Summary of operation
// - n-th store lands at address n, from one
// - at most fifty stores, last at address fifty
// - each store starts a write cycle, commands refused
// - address acknowledged only after write cycle ends
// - reset by command four or reset pin pulse
// - reset loads wiper from newest stored value
// - nothing stored: reset loads midscale
// - calibration bit selects mode, enabled by default
// - command nine with bit0 set shuts down
// - every command still runs during shutdown
// - command nine bit0 clear or reset wakes
// - wiper code selects exactly one tap
// - command four ignores data, reloads wiper
// - command nine bit0 picks shutdown or normal
// - calibration bit one off, zero on
// - command five returns location next frame
module otp_wiper_store_reset_shutdown #(
    parameter int WIPER_W = 10,
    parameter int PROG_CYCLES = rheo_pkg::PROG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_reset_n,
    output logic [WIPER_W-1:0] wiper_code,
    output logic [(1<<WIPER_W)-1:0] tap_sel,
    output logic terminal_a_connected,
    output logic calib_enable,
    output logic busy
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    generate
        if (WIPER_W != 8 && WIPER_W != 10) begin : g_bad_width
            $error("wiper width must be 8 or 10");
        end
        if (PROG_CYCLES < 1) begin : g_bad_prog
            $error("write cycle needs at least one clock");
        end
    endgenerate

    localparam int TW = $clog2(PROG_CYCLES + 1);
    localparam logic [WIPER_W-1:0] MIDSCALE = WIPER_W'(1 << (WIPER_W - 1));

    // ----------------------------------------
    // state
    // ----------------------------------------
    rheo_pkg::state_t state_r;
    logic [TW-1:0] timer_r;
    logic [WIPER_W-1:0] wiper_register_r;
    logic [WIPER_W-1:0] otp_wiper_memory_r [1:rheo_pkg::OTP_LAST];
    logic [rheo_pkg::ADDR_W-1:0] last_addr_r;
    logic [rheo_pkg::CTRL_W-1:0] ctrl_r;
    logic shutdown_r;
    logic [rheo_pkg::FRAME_W-1:0] serial_data_out_r;
    logic [31:0] prdata_r;
    logic rst_pin_s1_r;
    logic rst_pin_s2_r;
    logic rst_pin_s3_r;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic wr_acc;
    logic addr_ok;
    logic cmd_go;
    logic cmd_refused;
    rheo_pkg::cmd_t cmd;
    logic [rheo_pkg::DATA_W-1:0] cmd_data;
    logic [rheo_pkg::ADDR_W-1:0] rd_addr;
    logic hw_pulse;
    logic do_reset;
    logic store_ok;
    logic [WIPER_W-1:0] otp_rd;
    logic [WIPER_W-1:0] reload_val;

    assign wr_acc = psel && penable && pwrite;
    assign addr_ok = (paddr == rheo_pkg::CMD_OFS) || (paddr == rheo_pkg::READBACK_OFS) ||
                     (paddr == rheo_pkg::STAT_OFS) || (paddr == rheo_pkg::WIPER_OFS);
    assign cmd = rheo_pkg::cmd_t'(pwdata[rheo_pkg::CMD_LSB +: rheo_pkg::CMD_W]);
    assign cmd_data = pwdata[rheo_pkg::DATA_W-1:0];
    // upper data bits are don't care for memory addressing
    assign rd_addr = cmd_data[rheo_pkg::ADDR_W-1:0];
    // command writes are refused with pslverr while the fuse write runs; reads are still served
    assign cmd_refused = wr_acc && (paddr == rheo_pkg::CMD_OFS) && (state_r != rheo_pkg::IDLE);
    assign cmd_go = wr_acc && (paddr == rheo_pkg::CMD_OFS) && (state_r == rheo_pkg::IDLE);

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || cmd_refused);
    assign prdata = prdata_r;

    // ----------------------------------------
    // reset pin synchroniser and pulse detect
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_pin_s1_r <= 1'b1;
            rst_pin_s2_r <= 1'b1;
            rst_pin_s3_r <= 1'b1;
        end else begin
            rst_pin_s1_r <= hw_reset_n;
            rst_pin_s2_r <= rst_pin_s1_r;
            rst_pin_s3_r <= rst_pin_s2_r;
        end
    end

    // act once, on the falling edge of the pin
    assign hw_pulse = rst_pin_s3_r && !rst_pin_s2_r;
    assign do_reset = hw_pulse || (cmd_go && cmd == rheo_pkg::CMD_SW_RESET);

    // ----------------------------------------
    // memory lookups
    // ----------------------------------------
    always_comb begin
        otp_rd = '0;
        if (rd_addr >= rheo_pkg::OTP_FIRST && rd_addr <= rheo_pkg::OTP_LAST) begin
            otp_rd = otp_wiper_memory_r[rd_addr];
        end
    end

    always_comb begin
        reload_val = MIDSCALE;
        if (last_addr_r != rheo_pkg::OTP_NONE) begin
            reload_val = otp_wiper_memory_r[last_addr_r];
        end
    end

    assign store_ok = cmd_go && (cmd == rheo_pkg::CMD_STORE) && ctrl_r[rheo_pkg::CTRL_PROG_EN] &&
                      (last_addr_r != rheo_pkg::OTP_LAST);

    // ----------------------------------------
    // write cycle sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= rheo_pkg::IDLE;
            timer_r <= '0;
        end else begin
            unique case (state_r)
                rheo_pkg::IDLE: begin
                    if (store_ok) begin
                        state_r <= rheo_pkg::PROGRAMMING;
                        timer_r <= TW'(PROG_CYCLES - 1);
                    end
                end
                rheo_pkg::PROGRAMMING: begin
                    if (timer_r == '0) begin
                        state_r <= rheo_pkg::IDLE;
                    end else begin
                        timer_r <= timer_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // nonvolatile memory and fill pointer
    // ----------------------------------------
    // flops stand in for fuses, so they only clear at power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr_r <= rheo_pkg::OTP_NONE;
            for (int i = 1; i <= rheo_pkg::OTP_LAST; i++) begin
                otp_wiper_memory_r[i] <= '0;
            end
        end else if (store_ok) begin
            otp_wiper_memory_r[last_addr_r + 1'b1] <= wiper_register_r;
            last_addr_r <= last_addr_r + 1'b1;
        end
    end

    // ----------------------------------------
    // wiper register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wiper_register_r <= MIDSCALE;
        end else if (do_reset) begin
            wiper_register_r <= reload_val;
        end else if (cmd_go && cmd == rheo_pkg::CMD_WR_WIPER && ctrl_r[rheo_pkg::CTRL_WR_EN]) begin
            // narrow variant takes the top bits, low two are don't care
            wiper_register_r <= cmd_data[rheo_pkg::DATA_W-1 -: WIPER_W];
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= rheo_pkg::CTRL_RST;
        end else begin
            if (cmd_go && cmd == rheo_pkg::CMD_WR_CTRL) begin
                ctrl_r[rheo_pkg::CTRL_CAL_DIS:0] <= cmd_data[rheo_pkg::CTRL_CAL_DIS:0];
            end
            // success flag drops at launch, rises when the cycle completes
            if (store_ok) begin
                ctrl_r[rheo_pkg::CTRL_PROG_OK] <= 1'b0;
            end else if (state_r == rheo_pkg::PROGRAMMING && timer_r == '0) begin
                ctrl_r[rheo_pkg::CTRL_PROG_OK] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // shutdown
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_r <= 1'b0;
        end else if (do_reset) begin
            shutdown_r <= 1'b0;
        end else if (cmd_go && cmd == rheo_pkg::CMD_SHUTDOWN) begin
            shutdown_r <= cmd_data[0];
        end
    end

    // ----------------------------------------
    // readback frame
    // ----------------------------------------
    // with no read pending the next frame echoes the command word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_data_out_r <= '0;
        end else if (cmd_go) begin
            serial_data_out_r <= pwdata[rheo_pkg::FRAME_W-1:0];
            unique case (cmd)
                rheo_pkg::CMD_RD_WIPER: begin
                    serial_data_out_r <= '0;
                    serial_data_out_r[rheo_pkg::DATA_W-1 -: WIPER_W] <= wiper_register_r;
                end
                rheo_pkg::CMD_RD_OTP: begin
                    serial_data_out_r <= '0;
                    serial_data_out_r[rheo_pkg::DATA_W-1 -: WIPER_W] <= otp_rd;
                end
                rheo_pkg::CMD_RD_LAST: begin
                    serial_data_out_r <= {{(rheo_pkg::FRAME_W - rheo_pkg::ADDR_W){1'b0}}, last_addr_r};
                end
                rheo_pkg::CMD_RD_CTRL: begin
                    serial_data_out_r <= {{(rheo_pkg::FRAME_W - rheo_pkg::CTRL_W){1'b0}}, ctrl_r};
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // bus read data, captured in the setup cycle
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= '0;
            unique case (paddr)
                rheo_pkg::READBACK_OFS: begin
                    prdata_r[rheo_pkg::FRAME_W-1:0] <= serial_data_out_r;
                end
                rheo_pkg::STAT_OFS: begin
                    prdata_r[rheo_pkg::ST_BUSY] <= (state_r != rheo_pkg::IDLE);
                    prdata_r[rheo_pkg::ST_ACK] <= (state_r == rheo_pkg::IDLE);
                    prdata_r[rheo_pkg::ST_SHDN] <= shutdown_r;
                    prdata_r[rheo_pkg::ST_CAL_DIS] <= ctrl_r[rheo_pkg::CTRL_CAL_DIS];
                    prdata_r[rheo_pkg::ST_LAST_LSB +: rheo_pkg::ADDR_W] <= last_addr_r;
                end
                rheo_pkg::WIPER_OFS: begin
                    prdata_r[WIPER_W-1:0] <= wiper_register_r;
                end
                rheo_pkg::CMD_OFS: begin
                    prdata_r[rheo_pkg::CTRL_W-1:0] <= ctrl_r;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // analog-facing outputs
    // ----------------------------------------
    tap_if #(.WIPER_W(WIPER_W)) taps ();

    assign taps.code = wiper_register_r;

    wiper_tap_decoder #(.WIPER_W(WIPER_W)) u_dec (
        .taps(taps)
    );

    assign tap_sel = taps.tap_sel;
    assign wiper_code = wiper_register_r;
    assign terminal_a_connected = !shutdown_r;
    assign calib_enable = !ctrl_r[rheo_pkg::CTRL_CAL_DIS];
    assign busy = (state_r != rheo_pkg::IDLE);
endmodule

// [design/rheo_pkg.sv]
package rheo_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] READBACK_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] WIPER_OFS = 8'h0c;

    // ----------------------------------------
    // command frame layout
    // ----------------------------------------
    localparam int CMD_LSB = 10;
    localparam int CMD_W = 4;
    localparam int DATA_W = 10;
    localparam int FRAME_W = 16;
    localparam int ADDR_W = 6;

    // ----------------------------------------
    // nonvolatile wiper memory
    // ----------------------------------------
    localparam logic [5:0] OTP_NONE = 6'h00;
    localparam logic [5:0] OTP_FIRST = 6'h01;
    localparam logic [5:0] OTP_LAST = 6'h32;

    // ----------------------------------------
    // control register bits and reset value
    // ----------------------------------------
    localparam int CTRL_PROG_EN = 0;
    localparam int CTRL_WR_EN = 1;
    localparam int CTRL_CAL_DIS = 2;
    localparam int CTRL_PROG_OK = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // ----------------------------------------
    // status register bits
    // ----------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_ACK = 1;
    localparam int ST_SHDN = 2;
    localparam int ST_CAL_DIS = 3;
    localparam int ST_LAST_LSB = 4;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 100000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_WR_WIPER,
        CMD_RD_WIPER,
        CMD_STORE,
        CMD_SW_RESET,
        CMD_RD_OTP,
        CMD_RD_LAST,
        CMD_WR_CTRL,
        CMD_RD_CTRL,
        CMD_SHUTDOWN
    } cmd_t;

    typedef enum logic {
        IDLE,
        PROGRAMMING
    } state_t;

endpackage

// [design/tap_if.sv]
interface tap_if #(
    parameter int WIPER_W = 10
);
    logic [WIPER_W-1:0] code;
    logic [(1<<WIPER_W)-1:0] tap_sel;

    modport ctl (output code, input tap_sel);
    modport dec (input code, output tap_sel);
endinterface

// [design/wiper_tap_decoder.sv]
module wiper_tap_decoder #(
    parameter int WIPER_W = 10
) (
    tap_if.dec taps
);
    // ----------------------------------------
    // one-hot tap select
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < (1 << WIPER_W); i++) begin : g_tap
            assign taps.tap_sel[i] = (taps.code == WIPER_W'(i));
        end
    endgenerate
endmodule

// [dv/apb_host.sv]
module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // holds the request until pready is seen; gives up after 50 cycles
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// [dv/rheo_properties.sv]
module rheo_properties #(
    parameter int WIPER_W = 10,
    parameter int PROG_CYCLES = rheo_pkg::PROG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_reset_n,
    input wire logic [WIPER_W-1:0] wiper_code,
    input wire logic [(1<<WIPER_W)-1:0] tap_sel,
    input wire logic terminal_a_connected,
    input wire logic calib_enable,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] busy_cnt_r;

    // ----------------------------------------
    // write cycle length, counted in samples
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_r <= '0;
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r + 1;
        end else begin
            busy_cnt_r <= '0;
        end
    end

    // accepted command: a busy device ignores the frame
    sequence cmd_wr;
        psel && penable && pwrite && paddr == rheo_pkg::CMD_OFS && !busy;
    endsequence
    sequence pin_fall;
        $fell(hw_reset_n);
    endsequence

    a_tap_onehot: assert property ($onehot(tap_sel) && tap_sel[wiper_code])
        else $error("tap select does not match wiper code");
    a_calib_bit: assert property (cmd_wr ##0 pwdata[13:10] == 4'h7 |=> calib_enable != $past(pwdata[2]))
        else $error("calibration enable does not follow control bit");
    a_shdn_cmd: assert property (cmd_wr ##0 pwdata[13:10] == 4'h9 |=> terminal_a_connected != $past(pwdata[0]))
        else $error("shutdown command not applied");
    a_sw_wake: assert property (cmd_wr ##0 pwdata[13:10] == 4'h4 |=> terminal_a_connected)
        else $error("software reset left shutdown on");
    a_busy_refuse: assert property (psel && penable && pwrite && paddr == rheo_pkg::CMD_OFS && busy |-> pslverr)
        else $error("command accepted during write cycle");
    a_poll_ack: assert property (psel && !penable && !pwrite && paddr == rheo_pkg::STAT_OFS |=> prdata[rheo_pkg::ST_ACK] == !$past(busy))
        else $error("address acknowledge wrong during write cycle");
    a_busy_len: assert property ($fell(busy) |-> busy_cnt_r == PROG_CYCLES)
        else $error("write cycle length wrong");
    a_pin_wake: assert property (pin_fall |-> ##3 terminal_a_connected)
        else $error("reset pin did not end shutdown");
    a_reset_mid: assert property ($rose(presetn) |-> wiper_code == WIPER_W'(1 << (WIPER_W - 1)))
        else $error("wiper not midscale after reset");
endmodule

bind otp_wiper_store_reset_shutdown rheo_properties #(.WIPER_W(WIPER_W), .PROG_CYCLES(PROG_CYCLES)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_reset_n(hw_reset_n),
    .wiper_code(wiper_code), .tap_sel(tap_sel), .terminal_a_connected(terminal_a_connected),
    .calib_enable(calib_enable), .busy(busy));

// [dv/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 4;
    logic pclk, presetn, hw_reset_n, psel, penable, pwrite, pready, pslverr, busy, term_a, calib, err, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] wiper, w;
    logic [1023:0] taps;
    logic [9:0] mem [1:50];
    int err_total, num_checks, seed, i, n;

`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, s); end end

    otp_wiper_store_reset_shutdown #(.WIPER_W(10), .PROG_CYCLES(PC)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_reset_n(hw_reset_n),
        .wiper_code(wiper), .tap_sel(taps), .terminal_a_connected(term_a), .calib_enable(calib), .busy(busy));
    apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [1023:0] onehot(input logic [9:0] c);
        return 1024'h1 << c;
    endfunction

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(wr, a, d, q, err, ok);
        if (!ok) begin
            $display("[ERR] bus answer expected 1 seen 0");
            err_total++;
            end_of_test();
        end
        @(negedge pclk);
    endtask

    task cmd(input logic [3:0] c, input logic [9:0] d);
        xfer(1'b1, rheo_pkg::CMD_OFS, {18'h0, c, d});
    endtask

    task store(input logic [9:0] v);
        cmd(4'h1, v);
        cmd(4'h3, 10'h0);
        `CHK("busy", 1'b1, busy);
        cmd(4'h9, 10'h1);
        `CHK("refused", 1'b1, err);
        `CHK("no shutdown", 1'b1, term_a);
        for (n = 0; n < 100; n++) begin
            xfer(1'b0, rheo_pkg::STAT_OFS, 32'h0);
            if (q[rheo_pkg::ST_ACK] === 1'b1) break;
        end
        if (n == 100) begin
            $display("[ERR] poll ack expected 1 seen 0");
            err_total++;
            end_of_test();
        end
    endtask

    initial begin
        seed = 96630;
        err_total = 0;
        num_checks = 0;
        presetn = 1'b0;
        hw_reset_n = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK("wiper", 10'h200, wiper);
        `CHK("calib", 1'b1, calib);
        `CHK("taps", onehot(10'h200), taps);
        cmd(4'h7, 10'h3);
        w = 10'($random(seed));
        cmd(4'h1, w);
        `CHK("taps", onehot(w), taps);
        cmd(4'h4, 10'($random(seed)));
        `CHK("wiper", 10'h200, wiper);
        $display("test reset midscale done");
        for (i = 1; i <= 50; i++) begin
            mem[i] = 10'($random(seed));
            store(mem[i]);
            if (i == 1) begin
                cmd(4'h1, ~mem[1]);
                cmd(4'h4, 10'h3ff);
                `CHK("wiper", mem[1], wiper);
                xfer(1'b0, rheo_pkg::STAT_OFS, 32'h0);
                `CHK("first addr", 6'h01, q[9:4]);
            end
        end
        xfer(1'b0, rheo_pkg::STAT_OFS, 32'h0);
        `CHK("last", 6'h32, q[9:4]);
        cmd(4'h3, 10'h0);
        `CHK("busy", 1'b0, busy);
        for (i = 0; i < 8; i++) begin
            n = (i < 3) ? i * 25 : 1 + ($unsigned($random(seed)) % 50);
            cmd(4'h5, {4'($random(seed)), 6'(n)});
            xfer(1'b0, rheo_pkg::READBACK_OFS, 32'h0);
            `CHK("sdo", (n == 0) ? 10'h0 : mem[n], q[9:0]);
        end
        $display("test store and read done");
        cmd(4'h9, 10'h1);
        `CHK("term a", 1'b0, term_a);
        w = 10'($random(seed));
        cmd(4'h1, w);
        `CHK("wiper", w, wiper);
        cmd(4'h9, 10'h0);
        `CHK("term a", 1'b1, term_a);
        cmd(4'h9, 10'h1);
        cmd(4'h4, 10'h0);
        `CHK("term a", 1'b1, term_a);
        cmd(4'h1, w);
        cmd(4'h9, 10'h1);
        `CHK("term a", 1'b0, term_a);
        @(posedge pclk);
        hw_reset_n <= 1'b0;
        @(posedge pclk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        `CHK("term a", 1'b1, term_a);
        `CHK("wiper", mem[50], wiper);
        $display("test shutdown and reset done");
        cmd(4'h7, 10'h7);
        `CHK("calib", 1'b0, calib);
        cmd(4'h7, 10'h3);
        `CHK("calib", 1'b1, calib);
        cmd(4'h2, 10'h0);
        xfer(1'b0, rheo_pkg::READBACK_OFS, 32'h0);
        `CHK("rd wiper", {6'h0, mem[50]}, q[15:0]);
        cmd(4'h6, 10'h0);
        xfer(1'b0, rheo_pkg::READBACK_OFS, 32'h0);
        `CHK("rd last", 16'h0032, q[15:0]);
        cmd(4'h8, 10'h0);
        xfer(1'b0, rheo_pkg::READBACK_OFS, 32'h0);
        `CHK("rd ctrl", 16'h000b, q[15:0]);
        cmd(4'h7, 10'h0);
        cmd(4'h1, ~mem[50]);
        cmd(4'h3, 10'h0);
        `CHK("busy", 1'b0, busy);
        xfer(1'b0, rheo_pkg::WIPER_OFS, 32'h0);
        `CHK("wiper reg", mem[50], q[9:0]);
        xfer(1'b0, rheo_pkg::CMD_OFS, 32'h0);
        `CHK("ctrl reg", 4'h8, q[3:0]);
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 1'b1, err);
        $display("test control and map done");
        end_of_test();
    end
endmodule
